/* hdl/lbr_regs.svh */
// Register offsets, field positions, reset values and timing figures of the LED ramp block
`ifndef LBR_REGS_SVH
`define LBR_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LBR_OFS_GP_CTRL 8'h10
`define LBR_OFS_PIN_CTRL 8'h80
`define LBR_OFS_MAIN_BRIGHT 8'hA0
`define LBR_OFS_SUB_BRIGHT 8'hB0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LBR_RST_GP_CTRL 8'hC0
`define LBR_RST_PIN_CTRL 8'hF8
`define LBR_RST_BRIGHT 8'hE0
`define LBR_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------------------
// General purpose control fields
// ----------------------------------------------------------------------------
`define LBR_GP_MAIN_EN 0
`define LBR_GP_SUB_EN 1
`define LBR_GP_UNISON 2
`define LBR_GP_RAMP_LO 3
`define LBR_GP_RAMP_HI 4
`define LBR_GP_FB_MODE 5
`define LBR_GP_RW_MASK 8'h3F
`define LBR_GP_RO_ONES 8'hC0

// ----------------------------------------------------------------------------
// Pin function control fields
// ----------------------------------------------------------------------------
`define LBR_PIN_ENABLE 0
`define LBR_PIN_DIR 1
`define LBR_PIN_DATA 2
`define LBR_PIN_RO_ONES 8'hF8

// ----------------------------------------------------------------------------
// Brightness code field
// ----------------------------------------------------------------------------
`define LBR_CODE_MSB 4

// ----------------------------------------------------------------------------
// Timing, in nanoseconds
// ----------------------------------------------------------------------------
`define LBR_CLK_PERIOD_NS 100
`define LBR_STEP_51US_NS 51000
`define LBR_STEP_13MS_NS 13000000
`define LBR_STEP_26MS_NS 26000000
`define LBR_STEP_52MS_NS 52000000

`endif

/* hdl/lbr_pkg.sv */
// Types shared by the LED ramp block files
package lbr_pkg;

  // Five-bit sink current code
  typedef logic [4:0] lbr_code_t;

  // Applied current in thousandths of a percent of full scale
  typedef logic [16:0] lbr_level_t;

  // Register byte
  typedef logic [7:0] lbr_byte_t;

  // Function of the multi-function pin
  typedef enum logic [1:0] {
    LBR_PIN_AS_RESET,
    LBR_PIN_AS_INPUT,
    LBR_PIN_AS_OUTPUT
  } lbr_pin_mode_e;

endpackage : lbr_pkg

/* hdl/lbr_ramp.sv */
// One sink's ramp engine: walks the applied code toward its target one step at a time
`timescale 1ns/100ps
module lbr_ramp #(
  parameter int CODE_W = 5,
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  // Target and pacing
  input wire logic [CODE_W-1:0] target_in,
  input wire logic [CNT_W-1:0] step_cycles_in,
  // Applied code
  output logic [CODE_W-1:0] code_out,
  output logic busy_out
);

  // Latched target, so a change of target is seen as a new request
  logic [CODE_W-1:0] target_q;
  // Cycles left until the next step
  logic [CNT_W-1:0] timer;

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  // New target differs from the one being chased
  wire retarget = (target_in != target_q);
  // First step toward a new target starts from the applied code
  wire [CODE_W-1:0] first_step = (target_in > code_out) ? CODE_W'(code_out + 1'b1)
                                                         : CODE_W'(code_out - 1'b1);
  // Later steps toward the latched target
  wire [CODE_W-1:0] next_step = (target_q > code_out) ? CODE_W'(code_out + 1'b1)
                                                       : CODE_W'(code_out - 1'b1);
  wire at_target = (code_out == target_q);
  wire timer_done = (timer == '0);
  wire [CNT_W-1:0] reload = CNT_W'(step_cycles_in - 1'b1);

  // ----------------------------------------------------------------------------
  // Step engine
  // ----------------------------------------------------------------------------
  // The first code moves at once, the rest one per step period
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      target_q <= '0;
      code_out <= '0;
      timer <= '0;
    end else if (clear_in) begin
      target_q <= '0;
      code_out <= '0;
      timer <= '0;
    end else if (retarget) begin
      // Retarget from whatever code is applied now
      target_q <= target_in;
      if (target_in != code_out) begin
        code_out <= first_step;
      end
      timer <= reload;
    end else if (!at_target) begin
      // Walk code by code, never a jump
      if (timer_done) begin
        code_out <= next_step;
        timer <= reload;
      end else begin
        timer <= CNT_W'(timer - 1'b1);
      end
    end
  end

  // Still walking toward the target
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
    end else if (clear_in) begin
      busy_out <= 1'b0;
    end else if (retarget) begin
      busy_out <= (first_step != target_in) && (target_in != code_out);
    end else if (!at_target && timer_done) begin
      busy_out <= (next_step != target_q);
    end
  end

endmodule : lbr_ramp

/* hdl/lbr_top.sv */
// LED brightness control: registers, unison select, ramp engines and multi-function pin
// How it works
// - Non-unison: each sink uses its own register
// - Eight-bit brightness registers, only five low bits used
// - Unison: main register drives both sinks
// - Code maps to 32 rising exponential levels
// - Applied code steps toward written value
// - Two ramp bits pick one of four periods
// - Transition lasts step period times difference minus one
// - Pin defaults to active-low reset input
// - Enable bit turns pin into general purpose
// - Input mode: bit 2 reads pin level
// - Output mode: bit 2 low pulls pin low
// - Settings hold while host stays silent
// - Unison select is control bit 2
// - Ramp rate bits are control bits 3, 4
`timescale 1ns/100ps
`include "lbr_regs.svh"
module lbr_top #(
  parameter int unsigned STEP_51US_CYCLES = `LBR_STEP_51US_NS / `LBR_CLK_PERIOD_NS,
  parameter int unsigned STEP_13MS_CYCLES = `LBR_STEP_13MS_NS / `LBR_CLK_PERIOD_NS,
  parameter int unsigned STEP_26MS_CYCLES = `LBR_STEP_26MS_NS / `LBR_CLK_PERIOD_NS,
  parameter int unsigned STEP_52MS_CYCLES = `LBR_STEP_52MS_NS / `LBR_CLK_PERIOD_NS,
  parameter int CNT_W = 20
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port from the serial interface engine
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire lbr_pkg::lbr_byte_t reg_addr_in,
  input wire lbr_pkg::lbr_byte_t reg_wdata_in,
  output lbr_pkg::lbr_byte_t reg_rdata_out,
  // Multi-function pin, open drain
  input wire logic mfp_in,
  output logic mfp_out,
  output logic mfp_oe_out,
  output logic device_reset_out,
  // Sink controls
  output logic primary_sink_enable_out,
  output logic secondary_sink_enable_out,
  output logic voltage_feedback_mode_out,
  output lbr_pkg::lbr_code_t main_code_out,
  output lbr_pkg::lbr_code_t secondary_code_out,
  output lbr_pkg::lbr_level_t main_level_out,
  output lbr_pkg::lbr_level_t secondary_level_out,
  output logic ramp_busy_out
);
  import lbr_pkg::*;

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  // Writable bits of the general purpose control register
  lbr_byte_t gp_control;
  // Brightness registers, all eight bits kept for read back
  lbr_byte_t main_brightness_code;
  lbr_byte_t secondary_brightness_code;
  // Writable bits of the pin function register
  logic pin_enable;
  logic pin_dir;
  logic pin_data;
  // Pin synchroniser; only the second stage is read by logic
  logic mfp_meta;
  logic mfp_sync;

  // ----------------------------------------------------------------------------
  // Pin function decode
  // ----------------------------------------------------------------------------
  lbr_pin_mode_e pin_mode;
  assign pin_mode = !pin_enable ? LBR_PIN_AS_RESET :
                    pin_dir ? LBR_PIN_AS_OUTPUT :
                    LBR_PIN_AS_INPUT;

  // Pin held low in reset function clears the control, brightness and pin registers and both ramps
  wire soft_reset = (pin_mode == LBR_PIN_AS_RESET) && !mfp_sync;

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  wire hit_gp = (reg_addr_in == `LBR_OFS_GP_CTRL);
  wire hit_pin = (reg_addr_in == `LBR_OFS_PIN_CTRL);
  wire hit_main = (reg_addr_in == `LBR_OFS_MAIN_BRIGHT);
  wire hit_sub = (reg_addr_in == `LBR_OFS_SUB_BRIGHT);
  wire wr_gp = reg_wr_in && hit_gp;
  wire wr_pin = reg_wr_in && hit_pin;
  wire wr_main = reg_wr_in && hit_main;
  wire wr_sub = reg_wr_in && hit_sub;

  // ----------------------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------------------
  wire unison_select = gp_control[`LBR_GP_UNISON];
  wire ramp_rate_bit_low = gp_control[`LBR_GP_RAMP_LO];
  wire ramp_rate_bit_high = gp_control[`LBR_GP_RAMP_HI];

  // Only the five low bits steer the sinks; upper bits are don't care
  wire [`LBR_CODE_MSB:0] main_target = main_brightness_code[`LBR_CODE_MSB:0];
  wire [`LBR_CODE_MSB:0] sub_own = secondary_brightness_code[`LBR_CODE_MSB:0];

  // Unison hands the main code to both sinks and ignores the secondary one
  wire [`LBR_CODE_MSB:0] sub_target = unison_select ? main_target
                                                    : sub_own;

  // Step period select: low bit cleared and high set is the 13 ms pace
  wire [CNT_W-1:0] step_cycles =
    ( ramp_rate_bit_low &&  ramp_rate_bit_high) ? CNT_W'(STEP_52MS_CYCLES) :
    ( ramp_rate_bit_low && !ramp_rate_bit_high) ? CNT_W'(STEP_26MS_CYCLES) :
    (!ramp_rate_bit_low &&  ramp_rate_bit_high) ? CNT_W'(STEP_13MS_CYCLES) :
    CNT_W'(STEP_51US_CYCLES);

  // ----------------------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------------------
  // Input mode reads the pin itself, output mode the stored drive value
  wire pin_read_bit = (pin_mode == LBR_PIN_AS_INPUT) ? mfp_sync : pin_data;
  wire [7:0] pin_read = `LBR_PIN_RO_ONES |
                        {5'h00, pin_read_bit, pin_dir, pin_enable};
  wire [7:0] gp_read = `LBR_GP_RO_ONES | (gp_control & `LBR_GP_RW_MASK);
  wire [7:0] read_mux = hit_gp ? gp_read :
                        hit_pin ? pin_read :
                        hit_main ? main_brightness_code :
                        hit_sub ? secondary_brightness_code :
                        `LBR_UNMAPPED_READ;

  // ----------------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------------
  // Pin idles high through its pull-up, so the flops reset high
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mfp_meta <= 1'b1;
      mfp_sync <= 1'b1;
    end else begin
      mfp_meta <= mfp_in;
      mfp_sync <= mfp_meta;
    end
  end

  // ----------------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------------
  // Contents stay put until rewritten or reset, whatever the host does
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gp_control <= `LBR_RST_GP_CTRL & `LBR_GP_RW_MASK;
    end else if (soft_reset) begin
      gp_control <= `LBR_RST_GP_CTRL & `LBR_GP_RW_MASK;
    end else if (wr_gp) begin
      gp_control <= reg_wdata_in & `LBR_GP_RW_MASK;
    end
  end

  // ----------------------------------------------------------------------------
  // Brightness registers
  // ----------------------------------------------------------------------------
  // Secondary register still takes writes in unison; it is only bypassed
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_brightness_code <= `LBR_RST_BRIGHT;
      secondary_brightness_code <= `LBR_RST_BRIGHT;
    end else if (soft_reset) begin
      main_brightness_code <= `LBR_RST_BRIGHT;
      secondary_brightness_code <= `LBR_RST_BRIGHT;
    end else begin
      if (wr_main) begin
        main_brightness_code <= reg_wdata_in;
      end
      if (wr_sub) begin
        secondary_brightness_code <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin function register
  // ----------------------------------------------------------------------------
  // Upper bits are not stored at all, so writes to them vanish
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_enable <= 1'(`LBR_RST_PIN_CTRL >> `LBR_PIN_ENABLE);
      pin_dir <= 1'(`LBR_RST_PIN_CTRL >> `LBR_PIN_DIR);
      pin_data <= 1'(`LBR_RST_PIN_CTRL >> `LBR_PIN_DATA);
    end else if (soft_reset) begin
      pin_enable <= 1'b0;
      pin_dir <= 1'b0;
      pin_data <= 1'b0;
    end else if (wr_pin) begin
      pin_enable <= reg_wdata_in[`LBR_PIN_ENABLE];
      pin_dir <= reg_wdata_in[`LBR_PIN_DIR];
      pin_data <= reg_wdata_in[`LBR_PIN_DATA];
    end
  end

  // ----------------------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------------------
  // Captured on the read strobe and held until the next read
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `LBR_UNMAPPED_READ;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  // ----------------------------------------------------------------------------
  // Ramp engines
  // ----------------------------------------------------------------------------
  lbr_code_t main_applied;
  lbr_code_t sub_applied;
  logic main_busy;
  logic sub_busy;

  // Main sink ramp
  lbr_ramp #(
    .CODE_W(5),
    .CNT_W(CNT_W)
  ) u_main_ramp (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clear_in(soft_reset),
    .target_in(main_target),
    .step_cycles_in(step_cycles),
    .code_out(main_applied),
    .busy_out(main_busy)
  );

  // Secondary sink ramp; switching unison retargets it like a write would
  lbr_ramp #(
    .CODE_W(5),
    .CNT_W(CNT_W)
  ) u_sub_ramp (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .clear_in(soft_reset),
    .target_in(sub_target),
    .step_cycles_in(step_cycles),
    .code_out(sub_applied),
    .busy_out(sub_busy)
  );

  // ----------------------------------------------------------------------------
  // Code to current level
  // ----------------------------------------------------------------------------
  // Thousandths of a percent of full scale; rising and roughly exponential
  function automatic lbr_level_t code_to_level(input lbr_code_t code);
    lbr_level_t lvl;
    lvl = 17'h00000;
    case (code)
      5'h00: lvl = 17'h00000;
      5'h01: lvl = 17'h0007D;
      5'h02: lvl = 17'h00271;
      5'h03: lvl = 17'h003E8;
      5'h04: lvl = 17'h00465;
      5'h05: lvl = 17'h00521;
      5'h06: lvl = 17'h00698;
      5'h07: lvl = 17'h0080F;
      5'h08: lvl = 17'h00986;
      5'h09: lvl = 17'h00AFD;
      5'h0A: lvl = 17'h00C35;
      5'h0B: lvl = 17'h00EA6;
      5'h0C: lvl = 17'h01117;
      5'h0D: lvl = 17'h01482;
      5'h0E: lvl = 17'h0186A;
      5'h0F: lvl = 17'h01D4C;
      5'h10: lvl = 17'h0222E;
      5'h11: lvl = 17'h02710;
      5'h12: lvl = 17'h030D4;
      5'h13: lvl = 17'h03A98;
      5'h14: lvl = 17'h041EB;
      5'h15: lvl = 17'h0493E;
      5'h16: lvl = 17'h057E4;
      5'h17: lvl = 17'h0668A;
      5'h18: lvl = 17'h07A12;
      5'h19: lvl = 17'h0927C;
      5'h1A: lvl = 17'h0AAE6;
      5'h1B: lvl = 17'h0CD14;
      5'h1C: lvl = 17'h0EF42;
      5'h1D: lvl = 17'h11170;
      5'h1E: lvl = 17'h155CC;
      default: lvl = 17'h186A0;
    endcase
    return lvl;
  endfunction : code_to_level

  wire [16:0] main_level = code_to_level(main_applied);
  wire [16:0] sub_level = code_to_level(sub_applied);

  // ----------------------------------------------------------------------------
  // Sink outputs
  // ----------------------------------------------------------------------------
  // Registered so the analog side never sees decode glitches
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      main_code_out <= 5'h00;
      secondary_code_out <= 5'h00;
      main_level_out <= 17'h00000;
      secondary_level_out <= 17'h00000;
      ramp_busy_out <= 1'b0;
    end else begin
      main_code_out <= main_applied;
      secondary_code_out <= sub_applied;
      main_level_out <= main_level;
      secondary_level_out <= sub_level;
      ramp_busy_out <= main_busy || sub_busy;
    end
  end

  // Enables and mode follow the control register one cycle later
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      primary_sink_enable_out <= 1'b0;
      secondary_sink_enable_out <= 1'b0;
      voltage_feedback_mode_out <= 1'b0;
    end else begin
      primary_sink_enable_out <= gp_control[`LBR_GP_MAIN_EN];
      secondary_sink_enable_out <= gp_control[`LBR_GP_SUB_EN];
      voltage_feedback_mode_out <= gp_control[`LBR_GP_FB_MODE];
    end
  end

  // ----------------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------------
  // Open drain: only ever pulls low; a one releases the pin to the pull-up
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mfp_out <= 1'b0;
      mfp_oe_out <= 1'b0;
      device_reset_out <= 1'b0;
    end else begin
      mfp_out <= 1'b0;
      mfp_oe_out <= (pin_mode == LBR_PIN_AS_OUTPUT) && !pin_data;
      device_reset_out <= soft_reset;
    end
  end

endmodule : lbr_top

/* verif/lbr_top_sva.sv */
// Port-level assertions for the LED brightness ramp and pin block
`timescale 1ns/100ps
module lbr_top_sva (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Register port
  input wire logic reg_rd_in,
  input wire lbr_pkg::lbr_byte_t reg_addr_in,
  input wire lbr_pkg::lbr_byte_t reg_rdata_out,
  // Pin and sinks
  input wire logic mfp_in,
  input wire logic mfp_out,
  input wire logic mfp_oe_out,
  input wire logic device_reset_out,
  input wire lbr_pkg::lbr_code_t main_code_out,
  input wire lbr_pkg::lbr_code_t secondary_code_out,
  input wire lbr_pkg::lbr_level_t main_level_out
);
  import lbr_pkg::*;
  // ---------------------------------------------------------------
  // One clock domain, so clocking and disable are shared
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // Modular difference plus one stays in 0..2 when codes only step
  chk_main_one_step: assert property (
    !$past(device_reset_out) |-> 5'(main_code_out - $past(main_code_out) + 5'd1) <= 5'd2)
    else $error("main code jumped");
  chk_sec_one_step: assert property (
    !$past(device_reset_out) |->
    5'(secondary_code_out - $past(secondary_code_out) + 5'd1) <= 5'd2)
    else $error("secondary code jumped");
  chk_level_zero_code: assert property (
    main_code_out == 5'h00 && $past(main_code_out) == 5'h00 |-> main_level_out == 17'd0)
    else $error("zero code gives current");
  chk_level_full_code: assert property (
    main_code_out == 5'h1F && $past(main_code_out) == 5'h1F |-> main_level_out == 17'd100000)
    else $error("full code not full scale");
  chk_pin_never_high: assert property (mfp_out == 1'b0)
    else $error("pin driven high");
  chk_oe_not_reset: assert property (mfp_oe_out |-> !device_reset_out)
    else $error("pin drives while reset input");
  chk_reset_needs_low: assert property (
    $rose(device_reset_out) |-> !($past(mfp_in, 2) && $past(mfp_in, 3) && $past(mfp_in, 4)))
    else $error("reset without low pin");
  chk_unmapped_reads_zero: assert property (
    reg_rd_in && !(reg_addr_in inside {8'h10, 8'h80, 8'hA0, 8'hB0}) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_pin_upper_ones: assert property (
    reg_rd_in && reg_addr_in == 8'h80 |=> reg_rdata_out[7:3] == 5'h1F)
    else $error("pin upper bits not ones");
endmodule : lbr_top_sva

bind lbr_top lbr_top_sva i_lbr_top_sva (.clock_in(clock_in), .nrst_in(nrst_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_rdata_out(reg_rdata_out),
  .mfp_in(mfp_in), .mfp_out(mfp_out), .mfp_oe_out(mfp_oe_out),
  .device_reset_out(device_reset_out), .main_code_out(main_code_out),
  .secondary_code_out(secondary_code_out), .main_level_out(main_level_out));

/* verif/lbr_host_model.sv */
// Host model: byte strobes toward the block and the pulled-up pin wire
`timescale 1ns/100ps
module lbr_host_model (
  // Clock
  input wire logic clock_in,
  // Register strobes
  output logic reg_wr_out,
  output logic reg_rd_out,
  output lbr_pkg::lbr_byte_t reg_addr_out,
  output lbr_pkg::lbr_byte_t reg_wdata_out,
  input wire lbr_pkg::lbr_byte_t reg_rdata_in,
  // Pin wire
  input wire logic mfp_oe_in,
  input wire logic ext_low_in,
  output logic mfp_level_out
);
  import lbr_pkg::*;
  // Open drain with pull-up: any party pulling low wins
  assign mfp_level_out = !(mfp_oe_in || ext_low_in);
  // Quiet strobes from time zero
  initial begin
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // Byte write; released lines show inverted data, not stale values
  task automatic wr(input lbr_byte_t a, input lbr_byte_t d);
    @(posedge clock_in);
    reg_wr_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clock_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask : wr
  // Byte read; data is registered, so sample mid-cycle after the take
  task automatic rd(input lbr_byte_t a, output lbr_byte_t d);
    @(posedge clock_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clock_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    @(negedge clock_in);
    d = reg_rdata_in;
  endtask : rd
endmodule : lbr_host_model

/* verif/lbr_top_tb_top.sv */
// Self-checking bench for the LED brightness ramp and pin block
`timescale 1ns/100ps
module lbr_top_tb_top;
  import lbr_pkg::*;
  // ---------------------------------------------------------------
  // Clock, reset and wiring
  // ---------------------------------------------------------------
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ext_low = 1'b0; // Outside party pulling the pin
  logic reg_wr, reg_rd, mfp_level, mfp_out, mfp_oe, dev_rst, busy, en_m, en_s, fb;
  lbr_byte_t addr, wdata, rdata, d;
  lbr_code_t main_code, sec_code;
  lbr_level_t main_lvl, sec_lvl;
  int fails = 0;
  int samples_checked = 0;
  always #50 clock_in = ~clock_in;
  // Short step counts keep the slow rates affordable
  lbr_top #(.STEP_51US_CYCLES(5), .STEP_13MS_CYCLES(20), .STEP_26MS_CYCLES(40),
    .STEP_52MS_CYCLES(80)) i_lbr_top (.clock_in(clock_in), .nrst_in(nrst_in),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .mfp_in(mfp_level), .mfp_out(mfp_out), .mfp_oe_out(mfp_oe),
    .device_reset_out(dev_rst), .primary_sink_enable_out(en_m),
    .secondary_sink_enable_out(en_s), .voltage_feedback_mode_out(fb),
    .main_code_out(main_code), .secondary_code_out(sec_code), .main_level_out(main_lvl),
    .secondary_level_out(sec_lvl), .ramp_busy_out(busy));
  lbr_host_model i_lbr_host_model (.clock_in(clock_in), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .mfp_oe_in(mfp_oe), .ext_low_in(ext_low), .mfp_level_out(mfp_level));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input lbr_byte_t a, input lbr_byte_t exp);
    i_lbr_host_model.rd(a, d);
    check(17'(d), 17'(exp));
  endtask : rd_chk
  task automatic idle(input int n);
    repeat (n) @(negedge clock_in);
  endtask : idle
  // Pin level changes settle through the two-flop synchroniser
  task automatic pin(input logic low);
    @(posedge clock_in);
    ext_low <= low;
    idle(6);
  endtask : pin
  task automatic wait_idle();
    int i;
    idle(4);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clock_in);
    check(17'(busy), 17'd0);
  endtask : wait_idle
  // Time from first step to arrival is (difference - 1) step periods
  task automatic ramp(input lbr_byte_t v, input int period);
    lbr_code_t start;
    int i;
    int k;
    int df;
    start = main_code;
    df = (v[4:0] > start) ? v[4:0] - start : start - v[4:0];
    i_lbr_host_model.wr(8'hA0, v);
    for (i = 0; i < 1000 && main_code === start; i++) @(negedge clock_in);
    for (k = 0; k < 1000 && main_code !== v[4:0]; k++) @(negedge clock_in);
    check(17'(k), 17'((df - 1) * period));
  endtask : ramp
  task automatic summarize();
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin : main_seq
    lbr_byte_t radr [5] = '{8'h10, 8'hA0, 8'hB0, 8'h80, 8'h20};
    lbr_byte_t rexp [5] = '{8'hC0, 8'hE0, 8'hE0, 8'hF8, 8'h00};
    int prd [4] = '{5, 40, 20, 80};
    int r;
    repeat (3) @(posedge clock_in);
    nrst_in <= 1'b1;
    for (r = 0; r < 5; r++) rd_chk(radr[r], rexp[r]);
    // Pin as reset, then as input, then as open-drain output
    pin(1'b1);
    check(17'(dev_rst), 17'd1);
    pin(1'b0);
    i_lbr_host_model.wr(8'h80, 8'h01);
    pin(1'b1);
    check(17'(dev_rst), 17'd0);
    rd_chk(8'h80, 8'hF9);
    pin(1'b0);
    rd_chk(8'h80, 8'hFD);
    i_lbr_host_model.wr(8'h80, 8'h03);
    idle(3);
    check(17'({mfp_oe, mfp_level}), 17'd2);
    i_lbr_host_model.wr(8'h80, 8'h07);
    idle(3);
    check(17'({mfp_oe, mfp_level}), 17'd1);
    rd_chk(8'h80, 8'hFF);
    // Control bits, then one ramp with ignored upper bits
    i_lbr_host_model.wr(8'h10, 8'h23);
    rd_chk(8'h10, 8'hE3);
    check(17'({en_m, en_s, fb}), 17'd7);
    i_lbr_host_model.wr(8'h10, 8'h03);
    ramp(8'hE5, 5);
    idle(2);
    check(main_lvl, 17'd1313);
    rd_chk(8'hA0, 8'hE5);
    // All four step periods
    for (r = 0; r < 4; r++) begin
      i_lbr_host_model.wr(8'h10, 8'(8'h03 | (r << 3)));
      ramp(r[0] ? 8'h05 : 8'h08, prd[r]);
    end
    // Independent, then unison sinks
    i_lbr_host_model.wr(8'h10, 8'h03);
    i_lbr_host_model.wr(8'hB0, 8'h03);
    wait_idle();
    check(17'({main_code, sec_code}), 17'({5'd5, 5'd3}));
    i_lbr_host_model.wr(8'h10, 8'h07);
    i_lbr_host_model.wr(8'hB0, 8'h1F);
    wait_idle();
    check(17'({main_code, sec_code}), 17'({5'd5, 5'd5}));
    ramp(8'h1F, 5);
    idle(2);
    check(main_lvl, 17'd100000);
    check(sec_lvl, 17'd100000);
    // Retarget mid-ramp, then silence must hold everything
    i_lbr_host_model.wr(8'hA0, 8'h00);
    idle(20);
    i_lbr_host_model.wr(8'hA0, 8'h1D);
    wait_idle();
    check(17'(main_code), 17'd29);
    idle(300);
    check(17'(main_code), 17'd29);
    rd_chk(8'h10, 8'hC7);
    summarize();
  end
  // Hang guard, far beyond the thousand or so cycles the tests need
  initial begin : watchdog
    #3000000;
    fails++;
    summarize();
  end
endmodule : lbr_top_tb_top
